// ---- logic/pss_defs.svh ----
// Offsets, field positions, reset values and timing for the set selector.
// Assumes a 50 MHz core clock and a 12-bit APB byte address.
`ifndef PSS_DEFS_SVH
`define PSS_DEFS_SVH
`define PSS_AW 12
`define PSS_OFS_CTRL 12'h000
`define PSS_OFS_SEL 12'h004
`define PSS_OFS_CMD 12'h008
`define PSS_OFS_DELAY 12'h00C
`define PSS_OFS_STATUS 12'h010
`define PSS_CTRL_SINGLE 0
`define PSS_CTRL_ASSIGN_PRI 1
`define PSS_CTRL_ASSIGN_ALT 2
`define PSS_CTRL_INVERT 3
`define PSS_ST_ACTIVE 0
`define PSS_ST_PENDING 1
`define PSS_ST_REJECT 2
`define PSS_ST_LEVEL 3
`define PSS_ST_READY 4
`define PSS_CTRL_RST 4'h0
`define PSS_SEL_RST 1'b0
`define PSS_DELAY_RST 15'h0000
`define PSS_DELAY_MAX 15'h4E20
`define PSS_CLK_NS 20
`define PSS_STEP_NS 10000000
`define PSS_STEP_CYCLES (`PSS_STEP_NS / `PSS_CLK_NS)
`define PSS_SETTLE 2'h2
`endif

// ---- logic/pss_pkg.sv ----
// Types shared by the protection set selector.
// Assumes the constants of pss_defs.svh.
package pss_pkg;
   typedef enum logic [1:0] {
      PSS_BOOT,
      PSS_PRIMARY,
      PSS_PENDING,
      PSS_ALTERNATE
   } pss_mode_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } pss_apb_req_t;

   typedef struct packed {
      logic sync1;
      logic sync2;
      pss_mode_t mode;
      logic [1:0] settle;
      logic [3:0] ctrl;
      logic sel;
      logic [14:0] delay;
      logic reject;
      logic [18:0] tick;
      logic [14:0] steps;
      logic active;
      logic switch_pulse;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pss_state_t;
endpackage

// ---- logic/pss_selector.sv ----
// Protection set selector: picks the primary or alternate protection set
// from a binary input, the panel selection or a remote command, with an
// APB slave for configuration and status.
// Assumes one core clock, synchronous reset, and an unsynchronised pin.
//
// Contract
// - Two protection sets are held; exactly one is active at any time.
// - Single-set operation always uses the primary set.
// - Requests come from the binary input, the panel and remote commands.
// - Switching is always allowed and pulses a timer and indicator reset; here the set is frozen while the input is assigned in one set only.
// - Assigned input level: low selects primary, high selects alternate.
// - Input change primary to alternate waits the promotion delay.
// - Input change alternate to primary happens at once.
// - While the input is assigned, panel and remote changes are refused.
// - At power-up the active set follows the assigned input state.
// - Alternate requested at power-up is taken without the delay.
// - Inverted polarity: energized selects primary, released alternate.
// - Input switching needs the input assigned in both sets.
// - Panel and remote share one selection; remote commands overwrite it.
// - Assigned input decides; otherwise the shared selection decides.
// - Refused remote commands are dropped, never kept for later.
// - Active-set indication is an output for contacts and lamps.
// - Promotion delay is 0 to 200 s in 0.01 s steps, default zero.
// - The active set is readable as a status value.
`timescale 1ns/1ns
`include "pss_defs.svh"

module pss_selector #(
   parameter int STEP_CYCLES = `PSS_STEP_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire pss_pkg::pss_apb_req_t apb_req_in,
   input wire logic set_select_pin_in,
   output logic apb_pready_out,
   output logic apb_pslverr_out,
   output logic [31:0] apb_prdata_out,
   output logic active_set_out,
   output logic set_switch_pulse_out
);

   ////////////////////////////////////////////////////////////////////////
   // State and decode

   pss_pkg::pss_state_t cur_ff;
   pss_pkg::pss_state_t nxt_cur;

   logic access;
   logic finish;
   logic hit;
   logic level_alt;
   logic assigned_any;
   logic assigned_both;
   logic want_alt;
   logic input_driven;
   logic delay_done;
   logic [31:0] rd_word;
   logic [18:0] tick_last;

   assign tick_last = 19'(STEP_CYCLES - 1);
   assign access = apb_req_in.psel && apb_req_in.penable;
   assign finish = access && cur_ff.pready;

   always_comb begin
      case (apb_req_in.paddr)
         `PSS_OFS_CTRL,
         `PSS_OFS_SEL,
         `PSS_OFS_CMD,
         `PSS_OFS_DELAY,
         `PSS_OFS_STATUS: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Set resolution

   // Polarity flip before anything else reads the level
   assign level_alt = cur_ff.sync2 ^ cur_ff.ctrl[`PSS_CTRL_INVERT];
   assign assigned_any = cur_ff.ctrl[`PSS_CTRL_ASSIGN_PRI] ||
      cur_ff.ctrl[`PSS_CTRL_ASSIGN_ALT];
   // Mismatched assignment freezes the set rather than guessing
   assign assigned_both = cur_ff.ctrl[`PSS_CTRL_ASSIGN_PRI] &&
      cur_ff.ctrl[`PSS_CTRL_ASSIGN_ALT];
   assign input_driven = !cur_ff.ctrl[`PSS_CTRL_SINGLE] && assigned_any;

   always_comb begin
      if (cur_ff.ctrl[`PSS_CTRL_SINGLE]) begin
         want_alt = 1'b0;
      end else if (assigned_any) begin
         if (assigned_both) begin
            want_alt = level_alt;
         end else begin
            want_alt = cur_ff.active;
         end
      end else begin
         want_alt = cur_ff.sel;
      end
   end

   assign delay_done = cur_ff.steps >= cur_ff.delay;

   ////////////////////////////////////////////////////////////////////////
   // Read mux

   always_comb begin
      rd_word = 32'h00000000;
      case (apb_req_in.paddr)
         `PSS_OFS_CTRL: rd_word[3:0] = cur_ff.ctrl;
         `PSS_OFS_SEL: rd_word[0] = cur_ff.sel;
         `PSS_OFS_DELAY: rd_word[14:0] = cur_ff.delay;
         `PSS_OFS_STATUS: begin
            rd_word[`PSS_ST_ACTIVE] = cur_ff.active;
            rd_word[`PSS_ST_PENDING] =
               (cur_ff.mode == pss_pkg::PSS_PENDING);
            rd_word[`PSS_ST_REJECT] = cur_ff.reject;
            rd_word[`PSS_ST_LEVEL] = level_alt;
            rd_word[`PSS_ST_READY] =
               (cur_ff.mode != pss_pkg::PSS_BOOT);
         end
         default: rd_word = 32'h00000000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      nxt_cur = cur_ff;
      // Two-stage synchroniser on the selection pin
      nxt_cur.sync1 = set_select_pin_in;
      nxt_cur.sync2 = cur_ff.sync1;
      nxt_cur.switch_pulse = 1'b0;

      // Bus: one wait cycle, data and error captured with pready
      nxt_cur.pready = access && !cur_ff.pready;
      nxt_cur.pslverr = access && !cur_ff.pready && !hit;
      if (access && !cur_ff.pready) begin
         nxt_cur.prdata = apb_req_in.pwrite ? 32'h00000000 : rd_word;
      end

      // Writes take effect only on the completing edge
      if (finish && apb_req_in.pwrite) begin
         case (apb_req_in.paddr)
            `PSS_OFS_CTRL: nxt_cur.ctrl = apb_req_in.pwdata[3:0];
            `PSS_OFS_SEL,
            `PSS_OFS_CMD: begin
               // Refused requests are dropped, not queued
               if (input_driven) begin
                  nxt_cur.reject = 1'b1;
               end else begin
                  nxt_cur.sel = apb_req_in.pwdata[0];
               end
            end
            `PSS_OFS_DELAY: begin
               if (apb_req_in.pwdata[14:0] > `PSS_DELAY_MAX ||
                   apb_req_in.pwdata[31:15] != 17'h00000) begin
                  nxt_cur.delay = `PSS_DELAY_MAX;
               end else begin
                  nxt_cur.delay = apb_req_in.pwdata[14:0];
               end
            end
            `PSS_OFS_STATUS: begin
               if (apb_req_in.pwdata[`PSS_ST_REJECT]) begin
                  nxt_cur.reject = 1'b0;
               end
            end
            default: nxt_cur.reject = cur_ff.reject;
         endcase
      end

      // Set selection
      case (cur_ff.mode)
         pss_pkg::PSS_BOOT: begin
            // Wait until the synchroniser holds the real pin level
            if (cur_ff.settle == `PSS_SETTLE) begin
               nxt_cur.active = want_alt;
               nxt_cur.mode = want_alt ? pss_pkg::PSS_ALTERNATE :
                  pss_pkg::PSS_PRIMARY;
            end else begin
               nxt_cur.settle = cur_ff.settle + 2'h1;
            end
         end
         pss_pkg::PSS_PRIMARY: begin
            nxt_cur.tick = 19'h00000;
            nxt_cur.steps = 15'h0000;
            if (want_alt) begin
               if (input_driven && cur_ff.delay != 15'h0000) begin
                  nxt_cur.mode = pss_pkg::PSS_PENDING;
               end else begin
                  nxt_cur.mode = pss_pkg::PSS_ALTERNATE;
                  nxt_cur.active = 1'b1;
                  nxt_cur.switch_pulse = 1'b1;
               end
            end
         end
         pss_pkg::PSS_PENDING: begin
            if (!want_alt) begin
               nxt_cur.mode = pss_pkg::PSS_PRIMARY;
            end else if (delay_done) begin
               nxt_cur.mode = pss_pkg::PSS_ALTERNATE;
               nxt_cur.active = 1'b1;
               nxt_cur.switch_pulse = 1'b1;
            end else if (cur_ff.tick == tick_last) begin
               nxt_cur.tick = 19'h00000;
               nxt_cur.steps = cur_ff.steps + 15'h0001;
            end else begin
               nxt_cur.tick = cur_ff.tick + 19'h00001;
            end
         end
         pss_pkg::PSS_ALTERNATE: begin
            if (!want_alt) begin
               nxt_cur.mode = pss_pkg::PSS_PRIMARY;
               nxt_cur.active = 1'b0;
               nxt_cur.switch_pulse = 1'b1;
            end
         end
         default: begin
            nxt_cur.mode = pss_pkg::PSS_PRIMARY;
            nxt_cur.active = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         cur_ff.sync1 <= 1'b0;
         cur_ff.sync2 <= 1'b0;
         cur_ff.mode <= pss_pkg::PSS_BOOT;
         cur_ff.settle <= 2'h0;
         cur_ff.ctrl <= `PSS_CTRL_RST;
         cur_ff.sel <= `PSS_SEL_RST;
         cur_ff.delay <= `PSS_DELAY_RST;
         cur_ff.reject <= 1'b0;
         cur_ff.tick <= 19'h00000;
         cur_ff.steps <= 15'h0000;
         cur_ff.active <= 1'b0;
         cur_ff.switch_pulse <= 1'b0;
         cur_ff.pready <= 1'b0;
         cur_ff.pslverr <= 1'b0;
         cur_ff.prdata <= 32'h00000000;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs, all straight from flops

   assign apb_pready_out = cur_ff.pready;
   assign apb_pslverr_out = cur_ff.pslverr;
   assign apb_prdata_out = cur_ff.prdata;
   // One set flag drives contacts and lamps alike
   assign active_set_out = cur_ff.active;
   assign set_switch_pulse_out = cur_ff.switch_pulse;

endmodule

// ---- verif/pss_pin_model.sv ----
// Binary input wiring model: drives the set selection pin.
// Assumes the bench asks for energize or release just after clock edges.
`timescale 1ns/1ns
module pss_pin_model (
   input wire logic core_clk_in,
   input wire logic energize_in,
   output logic pin_out
);
   // Contact wiring lags one clock, so the pin moves only on clock edges
   always_ff @(posedge core_clk_in) begin
      pin_out <= energize_in;
   end
endmodule

// ---- verif/pss_selector_props.sv ----
// Checker for pss_selector: APB answer, switching and promotion timing.
// Assumes CTRL and DELAY offsets of pss_defs.svh; sees top ports only.
`timescale 1ns/1ns
`include "pss_defs.svh"
module pss_selector_props #(
   parameter int STEP_CYCLES = 4
) (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire pss_pkg::pss_apb_req_t apb_req_in,
   input wire logic set_select_pin_in,
   input wire logic apb_pready_out,
   input wire logic apb_pslverr_out,
   input wire logic [31:0] apb_prdata_out,
   input wire logic active_set_out,
   input wire logic set_switch_pulse_out
);
   logic [3:0] ctrl_ff;
   logic [14:0] dly_ff;
   logic [31:0] hi_ff;
   logic wr, both, eff;
   assign wr = apb_req_in.psel & apb_req_in.pwrite & apb_pready_out;
   assign both = ctrl_ff[1] & ctrl_ff[2] & ~ctrl_ff[0];
   assign eff = set_select_pin_in ^ ctrl_ff[3];
   // Shadow of CTRL and DELAY; clamped delay writes are not tracked
   always_ff @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ctrl_ff <= 4'h0;
         dly_ff <= 15'h0000;
         hi_ff <= 32'h0;
      end else begin
         if (wr && apb_req_in.paddr == `PSS_OFS_CTRL) begin
            ctrl_ff <= apb_req_in.pwdata[3:0];
         end
         if (wr && apb_req_in.paddr == `PSS_OFS_DELAY) begin
            dly_ff <= apb_req_in.pwdata[14:0];
         end
         hi_ff <= (both && eff) ? hi_ff + 32'h1 : 32'h0;
      end
   end
   ////////////////////////////////////////////////////////////
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   AST_PULSE_ON_CHANGE: assert property (
      $changed(active_set_out) |-> set_switch_pulse_out)
      else $error("switch pulse missing");
   AST_PULSE_ONLY_CHANGE: assert property (
      set_switch_pulse_out |-> $changed(active_set_out))
      else $error("switch pulse without change");
   AST_APB_ANSWER: assert property (
      apb_req_in.psel && apb_req_in.penable && !apb_pready_out
      |=> apb_pready_out) else $error("pready late");
   AST_ERR_WITH_READY: assert property (
      apb_pslverr_out |-> apb_pready_out) else $error("lone pslverr");
   AST_BACK_TO_PRIMARY: assert property (
      (both && !eff) [*5] |-> !active_set_out)
      else $error("return to primary late");
   AST_SINGLE_SET: assert property (
      ctrl_ff[0] [*3] |-> !active_set_out) else $error("single set lost");
   AST_FROZEN: assert property (
      ((ctrl_ff[1] ^ ctrl_ff[2]) && !ctrl_ff[0]) [*3]
      |-> $stable(active_set_out)) else $error("set moved when frozen");
   AST_PROMO_MIN: assert property (
      $rose(active_set_out) && both |-> hi_ff >= dly_ff * STEP_CYCLES)
      else $error("promotion early");
   AST_PROMO_MAX: assert property (
      both && hi_ff == dly_ff * STEP_CYCLES + 16 |-> active_set_out)
      else $error("promotion late");
   cover property ($rose(active_set_out) && both);
   cover property (both && $fell(active_set_out));
   cover property (apb_pslverr_out);
endmodule
bind pss_selector pss_selector_props #(.STEP_CYCLES(STEP_CYCLES))
   i_pss_selector_props (.core_clk_in(core_clk_in),
   .sys_rst_in(sys_rst_in), .apb_req_in(apb_req_in),
   .set_select_pin_in(set_select_pin_in), .apb_pready_out(apb_pready_out),
   .apb_pslverr_out(apb_pslverr_out), .apb_prdata_out(apb_prdata_out),
   .active_set_out(active_set_out),
   .set_switch_pulse_out(set_switch_pulse_out));

// ---- verif/tb_top.sv ----
// Bench for pss_selector: APB tasks, pin model and panel scenarios.
// Assumes STEP_CYCLES of 4 and the offsets of pss_defs.svh.
`timescale 1ns/1ns
`include "pss_defs.svh"
module tb_top;
   logic core_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic energize = 1'b0;
   pss_pkg::pss_apb_req_t req = '0;
   logic pin, rdy, err, act, e, sw;
   logic [31:0] rd, q;
   int mismatches = 0;
   int checks = 0;
   always #10 core_clk_in = ~core_clk_in;
   pss_pin_model i_pss_pin_model (.core_clk_in(core_clk_in),
      .energize_in(energize), .pin_out(pin));
   pss_selector #(.STEP_CYCLES(4)) i_pss_selector (.core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in), .apb_req_in(req), .set_select_pin_in(pin),
      .apb_pready_out(rdy), .apb_pslverr_out(err), .apb_prdata_out(rd),
      .active_set_out(act), .set_switch_pulse_out(sw));
   ////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_in);
   endtask
   // Values read right after an edge are those that edge sampled
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_in);
      req <= '{1'b1, 1'b0, w, a, d};
      @(posedge core_clk_in);
      req.penable <= 1'b1;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1) begin
         mismatches++;
         end_of_test();
      end
      q = rd;
      e = err;
      req <= '0;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_regs();
      apb(1'b0, `PSS_OFS_CTRL, 32'h0);
      cmp(q, 32'h0);
      apb(1'b0, `PSS_OFS_STATUS, 32'h0);
      cmp(q, 32'h10);
      apb(1'b1, `PSS_OFS_DELAY, 32'h4E21);
      apb(1'b0, `PSS_OFS_DELAY, 32'h0);
      cmp(q, 32'h4E20);
      apb(1'b0, 12'h020, 32'h0);
      cmp({31'h0, e}, 32'h1);
      $display("regs done");
   endtask
   task automatic t_panel();
      apb(1'b1, `PSS_OFS_SEL, 32'h1);
      cyc(2);
      cmp({31'h0, act}, 32'h1);
      cmp({31'h0, sw}, 32'h1);
      apb(1'b1, `PSS_OFS_CMD, 32'h0);
      cyc(2);
      cmp({31'h0, act}, 32'h0);
      apb(1'b0, `PSS_OFS_SEL, 32'h0);
      cmp(q, 32'h0);
      apb(1'b1, `PSS_OFS_SEL, 32'h1);
      apb(1'b1, `PSS_OFS_CTRL, 32'h1);
      cyc(3);
      cmp({31'h0, act}, 32'h0);
      $display("panel done");
   endtask
   task automatic t_input();
      apb(1'b1, `PSS_OFS_DELAY, 32'h2);
      apb(1'b1, `PSS_OFS_CTRL, 32'h6);
      energize <= 1'b1;
      cyc(6);
      cmp({31'h0, act}, 32'h0);
      cyc(12);
      cmp({31'h0, act}, 32'h1);
      apb(1'b1, `PSS_OFS_SEL, 32'h0);
      apb(1'b0, `PSS_OFS_STATUS, 32'h0);
      cmp({31'h0, q[2]}, 32'h1);
      energize <= 1'b0;
      cyc(6);
      cmp({31'h0, act}, 32'h0);
      energize <= 1'b1;
      cyc(4);
      energize <= 1'b0;
      cyc(12);
      cmp({31'h0, act}, 32'h0);
      apb(1'b1, `PSS_OFS_CTRL, 32'h0);
      cyc(2);
      cmp({31'h0, act}, 32'h1);
      $display("input done");
   endtask
   task automatic t_invert();
      apb(1'b1, `PSS_OFS_DELAY, 32'h0);
      apb(1'b1, `PSS_OFS_CTRL, 32'hE);
      cyc(8);
      cmp({31'h0, act}, 32'h1);
      energize <= 1'b1;
      cyc(6);
      cmp({31'h0, act}, 32'h0);
      apb(1'b1, `PSS_OFS_CTRL, 32'h2);
      energize <= 1'b0;
      cyc(6);
      energize <= 1'b1;
      cyc(12);
      apb(1'b1, `PSS_OFS_CMD, 32'h1);
      cyc(3);
      cmp({31'h0, act}, 32'h0);
      $display("invert done");
   endtask
   initial begin
      repeat (20) @(posedge core_clk_in);
      sys_rst_in <= 1'b0;
      t_regs();
      t_panel();
      t_input();
      t_invert();
      end_of_test();
   end
endmodule
